//--- hdl/id_string_pkg.sv
package id_string_pkg;
  // ==========================================================
  // command addresses
  localparam logic [7:0] ADDR_NO_OP  = 8'h00;
  localparam logic [7:0] ADDR_MAKER  = 8'h02;
  localparam logic [7:0] ADDR_MODEL  = 8'h03;
  localparam logic [7:0] ADDR_SERIAL = 8'h04;
  localparam logic [7:0] ADDR_DATE   = 8'h05;
  localparam logic [7:0] ADDR_WINDOW = 8'h0B;

  // ==========================================================
  // response status field
  localparam logic [1:0] STAT_OK       = 2'h0;
  localparam logic [1:0] STAT_EXEC_ERR = 2'h1;
  localparam logic [1:0] STAT_STR_OK   = 2'h2;

  // ==========================================================
  // error condition codes
  localparam logic [3:0] ERR_OK        = 4'h0;
  localparam logic [3:0] ERR_NO_REG    = 4'h1;
  localparam logic [3:0] ERR_READ_ONLY = 4'h2;
  localparam logic [3:0] ERR_PENDING   = 4'h4;
  localparam logic [3:0] ERR_NOT_READY = 4'h5;
  localparam logic [3:0] ERR_RANGE     = 4'h6;
  localparam logic [3:0] ERR_WINDOW_RO = 4'h7;
  localparam logic [3:0] ERR_GEN_FAIL  = 4'h8;
  localparam logic [3:0] ERR_VENDOR    = 4'hF;

  // ==========================================================
  // string sizes and pointer
  localparam int         STR_MAX_BYTES  = 80;
  localparam int         DATE_BYTES     = 12;
  localparam logic [15:0] DATE_LEN      = 16'h000C;
  localparam logic [6:0] PTR_RESET      = 7'h00;
  localparam logic [6:0] PTR_STEP       = 7'h02;

  // ==========================================================
  // date string layout and characters
  localparam logic [7:0] ASCII_ZERO   = 8'h30;
  localparam logic [7:0] ASCII_HYPHEN = 8'h2D;
  localparam logic [7:0] ASCII_NUL    = 8'h00;
  localparam logic [23:0] MONTH_BAD   = 24'h3F_3F3F;
  localparam logic [23:0] MONTH_NAME [0:11] = '{
    24'h4A_414E, 24'h46_4542, 24'h4D_4152, 24'h41_5052,
    24'h4D_4159, 24'h4A_554E, 24'h4A_554C, 24'h41_5547,
    24'h53_4550, 24'h4F_4354, 24'h4E_4F56, 24'h44_4543};
  localparam logic [3:0] MONTH_FIRST = 4'h1;
  localparam logic [3:0] MONTH_LAST  = 4'hC;

  // ==========================================================
  // string selected for window access
  typedef enum logic [2:0] {SEL_NONE, SEL_MAKER, SEL_MODEL, SEL_SERIAL, SEL_DATE} str_sel_e;
endpackage : id_string_pkg

//--- hdl/string_pair_reader.sv
`timescale 1ns/100ps
// picks two adjacent bytes of a string, byte idx in the upper half
module string_pair_reader
  import id_string_pkg::*;
#(
  parameter int NBYTES = 80
) (
  input  wire logic [8*NBYTES-1:0] str_in,
  input  wire logic [6:0]          idx_in,
  output logic      [15:0]         pair_out
);
  logic [8*NBYTES-1:0] shifted;

  // ==========================================================
  // shift selected byte down; bytes past the field read as zero
  always_comb begin
    shifted  = str_in >> {idx_in, 3'b000};
    pair_out = {shifted[7:0], shifted[15:8]};
  end
endmodule : string_pair_reader

//--- hdl/date_string_former.sv
`timescale 1ns/100ps
// builds "DD-MON-YYYY\0", byte i at bits [8i+:8]
module date_string_former
  import id_string_pkg::*;
(
  input  wire logic [7:0]              day_bcd_in,
  input  wire logic [3:0]              month_in,
  input  wire logic [15:0]             year_bcd_in,
  output logic      [8*DATE_BYTES-1:0] date_str_out
);
  logic [23:0] mon;

  // ==========================================================
  // month lookup, then character placement
  always_comb begin
    if (month_in >= MONTH_FIRST && month_in <= MONTH_LAST) begin
      mon = MONTH_NAME[month_in - MONTH_FIRST];
    end else begin
      mon = MONTH_BAD;
    end
    date_str_out = {ASCII_NUL,
                    ASCII_ZERO | {4'h0, year_bcd_in[3:0]},
                    ASCII_ZERO | {4'h0, year_bcd_in[7:4]},
                    ASCII_ZERO | {4'h0, year_bcd_in[11:8]},
                    ASCII_ZERO | {4'h0, year_bcd_in[15:12]},
                    ASCII_HYPHEN,
                    mon[7:0], mon[15:8], mon[23:16],
                    ASCII_HYPHEN,
                    ASCII_ZERO | {4'h0, day_bcd_in[3:0]},
                    ASCII_ZERO | {4'h0, day_bcd_in[7:4]}};
  end
endmodule : date_string_former

//--- hdl/module_identity_string_registers.sv
`timescale 1ns/100ps
// How it works
// - reading the maker register points string access at the maker string.
// - successful maker read returns maker string length, null included, at most 80.
// - a write to the maker register gets an execution error.
// - reading the model register points string access at the model string.
// - successful model read returns model string length, at most 80.
// - a write to the model register changes nothing and gets an execution error.
// - reading the serial register points string access at the serial string.
// - successful serial read returns serial string length, at most 80.
// - a write to the serial register gets an execution error.
// - reading the date register points string access at the 12-byte date string.
// - successful date read returns 12; string is DD-MON-YYYY then null.
// - day is two digits with leading zero, year is four digits.
// - month is JAN to DEC, upper case, in calendar order.
// - a write to the date register errors and keeps the date.
// - a failed read returns execution error, zero data, and a cause code.
// - cause codes: not ready 5, general failure 8, vendor 15; pending 4 is never given.
// - after an error the host reads no-op; reading past a string gives 6.
module module_identity_string_registers
  import id_string_pkg::*;
#(
  parameter logic [8*STR_MAX_BYTES-1:0] MAKER_STR  = '0,
  parameter logic [15:0]                MAKER_LEN  = 16'h0001,
  parameter logic [8*STR_MAX_BYTES-1:0] MODEL_STR  = '0,
  parameter logic [15:0]                MODEL_LEN  = 16'h0001,
  parameter logic [8*STR_MAX_BYTES-1:0] SERIAL_STR = '0,
  parameter logic [15:0]                SERIAL_LEN = 16'h0001,
  parameter logic [7:0]                 DATE_DAY   = 8'h01,
  parameter logic [3:0]                 DATE_MONTH = 4'h1,
  parameter logic [15:0]                DATE_YEAR  = 16'h2000
) (
  input  wire logic        REF_CLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        CMD_VALID_IN,
  input  wire logic        CMD_WRITE_IN,
  input  wire logic [7:0]  CMD_ADDR_IN,
  input  wire logic [15:0] CMD_DATA_IN,
  input  wire logic        NOT_READY_IN,
  input  wire logic        EXEC_FAULT_IN,
  input  wire logic        VENDOR_FAULT_IN,
  output logic             RSP_VALID_OUT,
  output logic [1:0]       RSP_STATUS_OUT,
  output logic [15:0]      RSP_DATA_OUT,
  output logic [3:0]       ERR_CODE_OUT
);
  typedef struct packed {
    logic        rsp_valid;
    logic [1:0]  rsp_status;
    logic [15:0] rsp_data;
    logic [3:0]  err_code;
    str_sel_e    sel;
    logic [6:0]  ptr;
  } id_state_s;

  localparam id_state_s RESET_STATE = '{rsp_valid: 1'b0, rsp_status: STAT_OK,
                                        rsp_data: '0, err_code: ERR_OK,
                                        sel: SEL_NONE, ptr: PTR_RESET};

  id_state_s                   q;
  id_state_s                   next_q;
  logic [8*DATE_BYTES-1:0]     date_str;
  logic [15:0]                 pair_maker;
  logic [15:0]                 pair_model;
  logic [15:0]                 pair_serial;
  logic [15:0]                 pair_date;
  logic [15:0]                 cur_len;
  logic [15:0]                 cur_pair;
  logic                        id_addr;
  logic [15:0]                 id_len;
  str_sel_e                    id_sel;
  logic [15:0]                 unused_data;

  // ==========================================================
  // string sources
  date_string_former u_date (
    .day_bcd_in   (DATE_DAY),
    .month_in     (DATE_MONTH),
    .year_bcd_in  (DATE_YEAR),
    .date_str_out (date_str)
  );

  string_pair_reader #(.NBYTES(STR_MAX_BYTES)) u_pair_maker (
    .str_in (MAKER_STR), .idx_in (q.ptr), .pair_out (pair_maker));
  string_pair_reader #(.NBYTES(STR_MAX_BYTES)) u_pair_model (
    .str_in (MODEL_STR), .idx_in (q.ptr), .pair_out (pair_model));
  string_pair_reader #(.NBYTES(STR_MAX_BYTES)) u_pair_serial (
    .str_in (SERIAL_STR), .idx_in (q.ptr), .pair_out (pair_serial));
  string_pair_reader #(.NBYTES(DATE_BYTES)) u_pair_date (
    .str_in (date_str), .idx_in (q.ptr), .pair_out (pair_date));

  // ==========================================================
  // length and byte pair of the string now pointed at
  always_comb begin
    unused_data = CMD_DATA_IN;  // write data is never stored here
    case (q.sel)
      SEL_MAKER: begin
        cur_len  = MAKER_LEN;
        cur_pair = pair_maker;
      end
      SEL_MODEL: begin
        cur_len  = MODEL_LEN;
        cur_pair = pair_model;
      end
      SEL_SERIAL: begin
        cur_len  = SERIAL_LEN;
        cur_pair = pair_serial;
      end
      SEL_DATE: begin
        cur_len  = DATE_LEN;
        cur_pair = pair_date;
      end
      default: begin
        cur_len  = '0;
        cur_pair = '0;
      end
    endcase
  end

  // ==========================================================
  // decode of the four identity registers
  always_comb begin
    id_addr = 1'b1;
    case (CMD_ADDR_IN)
      ADDR_MAKER: begin
        id_len = MAKER_LEN;
        id_sel = SEL_MAKER;
      end
      ADDR_MODEL: begin
        id_len = MODEL_LEN;
        id_sel = SEL_MODEL;
      end
      ADDR_SERIAL: begin
        id_len = SERIAL_LEN;
        id_sel = SEL_SERIAL;
      end
      ADDR_DATE: begin
        id_len = DATE_LEN;
        id_sel = SEL_DATE;
      end
      default: begin
        id_addr = 1'b0;
        id_len  = '0;
        id_sel  = SEL_NONE;
      end
    endcase
  end

  // ==========================================================
  // command execution, answer always one cycle later
  always_comb begin
    next_q           = q;
    next_q.rsp_valid = CMD_VALID_IN;
    if (CMD_VALID_IN) begin
      next_q.rsp_data   = '0;
      next_q.rsp_status = STAT_EXEC_ERR;
      if (id_addr) begin
        if (CMD_WRITE_IN) begin
          next_q.err_code = ERR_READ_ONLY;
        end else if (NOT_READY_IN) begin
          next_q.err_code = ERR_NOT_READY;
        end else if (EXEC_FAULT_IN) begin
          next_q.err_code = ERR_GEN_FAIL;
        end else if (VENDOR_FAULT_IN) begin
          next_q.err_code = ERR_VENDOR;
        end else begin
          next_q.rsp_status = STAT_STR_OK;
          next_q.rsp_data   = id_len;
          next_q.err_code   = ERR_OK;
          next_q.sel        = id_sel;
          next_q.ptr        = PTR_RESET;
        end
      end else if (CMD_ADDR_IN == ADDR_WINDOW) begin
        if (CMD_WRITE_IN) begin
          next_q.err_code = ERR_WINDOW_RO;
        end else if ({9'h000, q.ptr} >= cur_len) begin
          next_q.err_code = ERR_RANGE;
        end else begin
          next_q.rsp_status = STAT_OK;
          next_q.rsp_data   = cur_pair;
          next_q.err_code   = ERR_OK;
          next_q.ptr        = 7'(q.ptr + PTR_STEP);
        end
      end else if (CMD_ADDR_IN == ADDR_NO_OP) begin
        // no-op read reports the cause code left by the last other command, zero after a success
        next_q.rsp_status = STAT_OK;
        next_q.rsp_data   = CMD_WRITE_IN ? '0 : {12'h000, q.err_code};
      end else begin
        next_q.err_code = ERR_NO_REG;
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      q <= RESET_STATE;
    end else begin
      q <= next_q;
    end
  end

  // ==========================================================
  // outputs
  always_comb begin
    RSP_VALID_OUT  = q.rsp_valid;
    RSP_STATUS_OUT = q.rsp_status;
    RSP_DATA_OUT   = q.rsp_data;
    ERR_CODE_OUT   = q.err_code;
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  logic rd_ok;
  assign rd_ok = CMD_VALID_IN && !CMD_WRITE_IN && !NOT_READY_IN
                 && !EXEC_FAULT_IN && !VENDOR_FAULT_IN;

  property p_answer_next;
    CMD_VALID_IN |=> RSP_VALID_OUT ##1 (!RSP_VALID_OUT || $past(CMD_VALID_IN));
  endproperty
  a_answer_next: assert property (p_answer_next)
    else $error("answer not exactly one cycle after command");

  property p_maker_len;
    rd_ok && CMD_ADDR_IN == ADDR_MAKER
      |=> RSP_STATUS_OUT == STAT_STR_OK && RSP_DATA_OUT == MAKER_LEN && q.sel == SEL_MAKER;
  endproperty
  a_maker_len: assert property (p_maker_len)
    else $error("maker read did not return its length");

  property p_model_point;
    rd_ok && CMD_ADDR_IN == ADDR_MODEL |=> q.sel == SEL_MODEL && q.ptr == PTR_RESET;
  endproperty
  a_model_point: assert property (p_model_point)
    else $error("model read did not point string access");

  property p_date_len;
    rd_ok && CMD_ADDR_IN == ADDR_DATE |=> RSP_DATA_OUT == DATE_LEN;
  endproperty
  a_date_len: assert property (p_date_len)
    else $error("date read did not return twelve");

  property p_write_refused;
    CMD_VALID_IN && CMD_WRITE_IN && id_addr
      |=> RSP_STATUS_OUT == STAT_EXEC_ERR && $stable(q.sel) && $stable(q.ptr);
  endproperty
  a_write_refused: assert property (p_write_refused)
    else $error("identity write not refused");

  property p_fail_zero;
    CMD_VALID_IN && !CMD_WRITE_IN && id_addr && NOT_READY_IN
      |=> RSP_STATUS_OUT == STAT_EXEC_ERR && RSP_DATA_OUT == 16'h0000
      && ERR_CODE_OUT == ERR_NOT_READY;
  endproperty
  a_fail_zero: assert property (p_fail_zero)
    else $error("failed read not answered with error and zero");

  property p_past_end;
    CMD_VALID_IN && !CMD_WRITE_IN && CMD_ADDR_IN == ADDR_WINDOW
      && {9'h000, q.ptr} >= cur_len |=> ERR_CODE_OUT == ERR_RANGE ##1
      (!$past(CMD_VALID_IN && CMD_ADDR_IN == ADDR_NO_OP && !CMD_WRITE_IN)
       || RSP_DATA_OUT == {12'h000, ERR_RANGE});
  endproperty
  a_past_end: assert property (p_past_end)
    else $error("read past string end not reported");

  property p_window_step;
    CMD_VALID_IN && !CMD_WRITE_IN && CMD_ADDR_IN == ADDR_WINDOW
      && {9'h000, q.ptr} < cur_len
      |=> RSP_DATA_OUT == $past(cur_pair) && q.ptr == 7'($past(q.ptr) + PTR_STEP);
  endproperty
  a_window_step: assert property (p_window_step)
    else $error("window read did not return pair and advance");

  property p_never_pending;
    ERR_CODE_OUT != ERR_PENDING;
  endproperty
  a_never_pending: assert property (p_never_pending)
    else $error("pending code reported");

  property p_date_shape;
    date_str[23:16] == ASCII_HYPHEN && date_str[55:48] == ASCII_HYPHEN
      && date_str[95:88] == ASCII_NUL && date_str[7:4] == ASCII_ZERO[7:4];
  endproperty
  a_date_shape: assert property (p_date_shape)
    else $error("date string layout wrong");

  // window is read-only: a write keeps the pointer where it was
  property p_window_ro;
    CMD_VALID_IN && CMD_WRITE_IN && CMD_ADDR_IN == ADDR_WINDOW
      |=> RSP_STATUS_OUT == STAT_EXEC_ERR && $stable(q.ptr);
  endproperty
  a_window_ro: assert property (p_window_ro)
    else $error("window write not refused");

  // lower-priority faults still give zero data and their own code
  property p_fault_codes;
    CMD_VALID_IN && !CMD_WRITE_IN && id_addr && !NOT_READY_IN
      && (EXEC_FAULT_IN || VENDOR_FAULT_IN)
      |=> RSP_STATUS_OUT == STAT_EXEC_ERR && RSP_DATA_OUT == 16'h0000
      && ERR_CODE_OUT == ($past(EXEC_FAULT_IN) ? ERR_GEN_FAIL : ERR_VENDOR);
  endproperty
  a_fault_codes: assert property (p_fault_codes)
    else $error("fault read gave wrong cause code");

  c_id_read: cover property (rd_ok && id_addr ##1 RSP_STATUS_OUT == STAT_STR_OK);
  c_window_ok: cover property (RSP_VALID_OUT && RSP_STATUS_OUT == STAT_OK && q.sel == SEL_DATE);
  c_past_end: cover property (ERR_CODE_OUT == ERR_RANGE);
  c_write_err: cover property (ERR_CODE_OUT == ERR_READ_ONLY);
endmodule : module_identity_string_registers

//--- tb/id_host_model.sv
`timescale 1ns/100ps
// host side of the command link: one command at a time, answer taken
module id_host_model (
  input  wire logic        clk_in,
  input  wire logic        rsp_valid_in,
  input  wire logic [1:0]  rsp_status_in,
  input  wire logic [15:0] rsp_data_in,
  input  wire logic [3:0]  err_code_in,
  output logic             cmd_valid_out,
  output logic             cmd_write_out,
  output logic [7:0]       cmd_addr_out,
  output logic [15:0]      cmd_data_out
);
  // ==========================================================
  // idle command lines at time zero
  initial begin
    cmd_valid_out = 1'b0;
    cmd_write_out = 1'b0;
    cmd_addr_out  = 8'h00;
    cmd_data_out  = 16'h0000;
  end

  // ==========================================================
  // one command pulse, then a bounded wait for its answer
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [15:0] wdata,
                      output logic [1:0] st, output logic [15:0] dat,
                      output logic [3:0] err, output int waits);
    @(posedge clk_in);
    cmd_valid_out <= 1'b1;
    cmd_write_out <= wr;
    cmd_addr_out  <= addr;
    cmd_data_out  <= wdata;
    @(posedge clk_in);
    // released lines show garbage, not the last command
    cmd_valid_out <= 1'b0;
    cmd_write_out <= ~wr;
    cmd_addr_out  <= ~addr;
    cmd_data_out  <= ~wdata;
    waits = 1;
    @(negedge clk_in);
    while (rsp_valid_in !== 1'b1 && waits < 4) begin
      @(negedge clk_in);
      waits++;
    end
    st  = rsp_status_in;
    dat = rsp_data_in;
    err = err_code_in;
  endtask : xfer
endmodule : id_host_model

//--- tb/module_identity_string_registers_bench.sv
`timescale 1ns/100ps
module module_identity_string_registers_bench;
  import id_string_pkg::*;
  // ==========================================================
  // packs a text so that character i sits at bits [8i+:8]
  function automatic logic [8*STR_MAX_BYTES-1:0] pack(input string s);
    logic [8*STR_MAX_BYTES-1:0] v;
    v = '0;
    for (int i = 0; i < s.len(); i++) v[8*i+:8] = s[i];
    return v;
  endfunction : pack

  localparam logic [8*STR_MAX_BYTES-1:0] STRS [3] = '{pack("ACME"), pack("TL-01"),
                                                      pack("S0042")};
  localparam logic [15:0] LENS [3] = '{16'h0005, 16'h0006, 16'h0006};
  localparam logic [8*STR_MAX_BYTES-1:0] DATE_TXT = pack("09-DEC-1999");

  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        not_ready = 1'b0;
  logic        exec_fault = 1'b0;
  logic        vendor_fault = 1'b0;
  logic        cmd_valid, cmd_write, rsp_valid;
  logic [7:0]  cmd_addr;
  logic [15:0] cmd_data, rsp_data;
  logic [1:0]  rsp_status;
  logic [3:0]  err_code;
  int          miscompares = 0;
  int          checks = 0;

  // ==========================================================
  // clock and units
  always #25 ref_clk = ~ref_clk;

  module_identity_string_registers #(
    .MAKER_STR(STRS[0]), .MAKER_LEN(LENS[0]), .MODEL_STR(STRS[1]), .MODEL_LEN(LENS[1]),
    .SERIAL_STR(STRS[2]), .SERIAL_LEN(LENS[2]), .DATE_DAY(8'h09), .DATE_MONTH(4'hC),
    .DATE_YEAR(16'h1999)
  ) u_dut (
    .REF_CLK_IN(ref_clk), .RST_N_IN(rst_n), .CMD_VALID_IN(cmd_valid),
    .CMD_WRITE_IN(cmd_write), .CMD_ADDR_IN(cmd_addr), .CMD_DATA_IN(cmd_data),
    .NOT_READY_IN(not_ready), .EXEC_FAULT_IN(exec_fault), .VENDOR_FAULT_IN(vendor_fault),
    .RSP_VALID_OUT(rsp_valid), .RSP_STATUS_OUT(rsp_status), .RSP_DATA_OUT(rsp_data),
    .ERR_CODE_OUT(err_code)
  );

  id_host_model u_host (
    .clk_in(ref_clk), .rsp_valid_in(rsp_valid), .rsp_status_in(rsp_status),
    .rsp_data_in(rsp_data), .err_code_in(err_code), .cmd_valid_out(cmd_valid),
    .cmd_write_out(cmd_write), .cmd_addr_out(cmd_addr), .cmd_data_out(cmd_data)
  );

  // ==========================================================
  // comparison and command helpers
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic cmd(input logic wr, input logic [7:0] addr, input logic [1:0] est,
                     input logic [15:0] edat, input logic [3:0] eerr);
    logic [1:0]  st;
    logic [15:0] dat;
    logic [3:0]  err;
    int          waits;
    u_host.xfer(wr, addr, 16'hA5A5, st, dat, err, waits);
    check({14'h0000, st}, {14'h0000, est});
    check(dat, edat);
    check({12'h000, err}, {12'h000, eerr});
    check(waits[15:0], 16'h0001);
  endtask : cmd

  // ==========================================================
  // scenarios
  task automatic test_date;
    logic [15:0] exp_pair;
    cmd(1'b0, ADDR_DATE, STAT_STR_OK, DATE_LEN, ERR_OK);
    for (int p = 0; p < DATE_BYTES; p += 2) begin
      exp_pair = {DATE_TXT[8*p+:8], DATE_TXT[8*p+8+:8]};
      cmd(1'b0, ADDR_WINDOW, STAT_OK, exp_pair, ERR_OK);
    end
    cmd(1'b0, ADDR_WINDOW, STAT_EXEC_ERR, 16'h0000, ERR_RANGE);
    cmd(1'b0, ADDR_NO_OP, STAT_OK, {12'h000, ERR_RANGE}, ERR_RANGE);
  endtask : test_date

  task automatic test_strings;
    logic [15:0] exp_pair;
    for (int k = 0; k < 3; k++) begin
      cmd(1'b0, ADDR_MAKER + 8'(k), STAT_STR_OK, LENS[k], ERR_OK);
      for (int p = 0; p < int'(LENS[k]); p += 2) begin
        exp_pair = {STRS[k][8*p+:8], STRS[k][8*p+8+:8]};
        cmd(1'b0, ADDR_WINDOW, STAT_OK, exp_pair, ERR_OK);
      end
      cmd(1'b0, ADDR_WINDOW, STAT_EXEC_ERR, 16'h0000, ERR_RANGE);
    end
  endtask : test_strings

  task automatic test_writes;
    cmd(1'b0, ADDR_MODEL, STAT_STR_OK, LENS[1], ERR_OK);
    cmd(1'b0, ADDR_WINDOW, STAT_OK, {STRS[1][7:0], STRS[1][15:8]}, ERR_OK);
    for (int a = 2; a < 6; a++) begin
      cmd(1'b1, 8'(a), STAT_EXEC_ERR, 16'h0000, ERR_READ_ONLY);
    end
    // pointer must survive the refused writes
    cmd(1'b0, ADDR_WINDOW, STAT_OK, {STRS[1][23:16], STRS[1][31:24]}, ERR_OK);
    cmd(1'b1, ADDR_WINDOW, STAT_EXEC_ERR, 16'h0000, ERR_WINDOW_RO);
    cmd(1'b0, 8'h20, STAT_EXEC_ERR, 16'h0000, ERR_NO_REG);
    cmd(1'b1, ADDR_NO_OP, STAT_OK, 16'h0000, ERR_NO_REG);
    cmd(1'b0, ADDR_DATE, STAT_STR_OK, DATE_LEN, ERR_OK);
    cmd(1'b0, ADDR_WINDOW, STAT_OK, {DATE_TXT[7:0], DATE_TXT[15:8]}, ERR_OK);
  endtask : test_writes

  task automatic test_faults;
    logic [2:0] vec [5];
    logic [3:0] code [5];
    vec = '{3'h4, 3'h2, 3'h1, 3'h7, 3'h3};
    code = '{ERR_NOT_READY, ERR_GEN_FAIL, ERR_VENDOR, ERR_NOT_READY, ERR_GEN_FAIL};
    for (int f = 0; f < 5; f++) begin
      @(posedge ref_clk);
      {not_ready, exec_fault, vendor_fault} <= vec[f];
      for (int a = 2; a < 6; a++) begin
        cmd(1'b0, 8'(a), STAT_EXEC_ERR, 16'h0000, code[f]);
      end
      cmd(1'b0, ADDR_NO_OP, STAT_OK, {12'h000, code[f]}, code[f]);
    end
    @(posedge ref_clk);
    {not_ready, exec_fault, vendor_fault} <= 3'h0;
    cmd(1'b0, ADDR_SERIAL, STAT_STR_OK, LENS[2], ERR_OK);
  endtask : test_faults

  // reset in mid-run drops the selected string and clears the answer
  task automatic test_reset;
    cmd(1'b0, ADDR_MAKER, STAT_STR_OK, LENS[0], ERR_OK);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    check({13'h0000, rsp_valid, rsp_status}, 16'h0000);
    check(rsp_data, 16'h0000);
    check({12'h000, err_code}, {12'h000, ERR_OK});
    cmd(1'b0, ADDR_WINDOW, STAT_EXEC_ERR, 16'h0000, ERR_RANGE);
  endtask : test_reset

  // ==========================================================
  // verdict and end of run
  task automatic finish_test;
    if (miscompares == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  // main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    test_date();
    test_strings();
    test_writes();
    test_faults();
    test_reset();
    finish_test();
  end

  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    finish_test();
  end
endmodule : module_identity_string_registers_bench
